// file: core/fgt_pkg.sv
// Purpose: constants for the converter fine gain trim bank
// Assumes: byte registers on an Avalon-MM slave, one 32-bit word each
// Notes:   printed offsets are register indices; byte address is index * 4
package fgt_pkg;
    localparam int          FGT_NUM_REGS   = 8;
    localparam int          FGT_ADDR_W     = 12;
    localparam int          FGT_TRIM_W     = 5;
    localparam int          FGT_REG_W      = 8;
    localparam int          FGT_TRIM_LSB   = 0;
    localparam int          FGT_TRIM_MSB   = 4;
    // register indices
    localparam logic [11:0] FGT_IDX_CONV0  = 12'h0360;
    localparam logic [11:0] FGT_IDX_CONV1  = 12'h0361;
    localparam logic [11:0] FGT_IDX_CONV2A = 12'h0362;
    localparam logic [11:0] FGT_IDX_CONV2B = 12'h0363;
    localparam logic [11:0] FGT_IDX_CONV3A = 12'h0364;
    localparam logic [11:0] FGT_IDX_CONV3B = 12'h0365;
    localparam logic [11:0] FGT_IDX_CONV4  = 12'h0366;
    localparam logic [11:0] FGT_IDX_CONV5  = 12'h0367;
    localparam logic [7:0]  FGT_REG_RESET  = 8'h00;
    localparam logic [31:0] FGT_UNMAPPED   = 32'h0000_0000;

    typedef enum logic [1:0] {
        FGT_IDLE,
        FGT_ANSWER
    } fgt_state_t;
endpackage : fgt_pkg

// file: core/fgt_trim_sel.sv
// Purpose: pick the active trim of a two-input converter core
// Assumes: input select comes from logic on the same clock
// Notes:   output registered, follows select one cycle later
module fgt_trim_sel
    import fgt_pkg::*;
(
    input  wire logic                  clk_sys_in,
    input  wire logic                  rstn_in,
    input  wire logic                  second_sel_in,
    input  wire logic [FGT_TRIM_W-1:0] first_trim_in,
    input  wire logic [FGT_TRIM_W-1:0] second_trim_in,
    output logic      [FGT_TRIM_W-1:0] trim_out
);
    typedef struct packed {
        logic [FGT_TRIM_W-1:0] trim;
    } fgt_sel_state_t;

    fgt_sel_state_t s_q;
    fgt_sel_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.trim = second_sel_in ? second_trim_in : first_trim_in;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign trim_out = s_q.trim;

    // RQ3 selected code applied
    property p_sel_follow;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 $past(rstn_in) |-> trim_out == ($past(second_sel_in) ? $past(second_trim_in) : $past(first_trim_in));
    endproperty
    a_sel_follow: assert property (p_sel_follow) else $error("active trim does not follow input select"); // RQ3
endmodule : fgt_trim_sel

// file: core/fgt_bank.sv
// Purpose: fine gain trim register bank for six converter cores
// Assumes: Avalon-MM slave, word addressed by byte address, fuse word valid at load
// Notes:   fuse defaults are loaded by a pulse after reset; reset itself gives zero
//
// Summary of operation
// RQ1 - cores zero, one: trim at 0x360, 0x361
// RQ2 - cores four, five: trim at 0x366, 0x367
// RQ3 - core two: trim chosen by sampled input
// RQ4 - core three: trim chosen by sampled input
// RQ5 - software keeps upper three bits zero
// RQ6 - defaults load from fuse memory
// RQ7 - trims driven continuously, effective after write
module fgt_bank
    import fgt_pkg::*;
(
    input  wire logic                              clk_sys_in,
    input  wire logic                              rstn_in,
    input  wire logic [FGT_ADDR_W+1:0]             avs_address_in,
    input  wire logic                              avs_read_in,
    input  wire logic                              avs_write_in,
    input  wire logic [31:0]                       avs_writedata_in,
    input  wire logic [3:0]                        avs_byteenable_in,
    output logic      [31:0]                       avs_readdata_out,
    output logic                                   avs_waitrequest_out,
    input  wire logic                              fuse_load_in,
    input  wire logic [FGT_NUM_REGS*FGT_REG_W-1:0] fuse_data_in,
    input  wire logic                              conv2_second_sel_in,
    input  wire logic                              conv3_second_sel_in,
    output logic      [FGT_TRIM_W-1:0]             conv0_trim_out,
    output logic      [FGT_TRIM_W-1:0]             conv1_trim_out,
    output logic      [FGT_TRIM_W-1:0]             conv2_trim_out,
    output logic      [FGT_TRIM_W-1:0]             conv3_trim_out,
    output logic      [FGT_TRIM_W-1:0]             conv4_trim_out,
    output logic      [FGT_TRIM_W-1:0]             conv5_trim_out
);
    typedef struct packed {
        fgt_state_t                           st;
        logic [FGT_NUM_REGS-1:0][FGT_REG_W-1:0] regs;
        logic [31:0]                          rdata;
        logic                                 waitreq;
    } fgt_bank_state_t;

    fgt_bank_state_t s_q;
    fgt_bank_state_t s_d;

    logic [FGT_ADDR_W-1:0] idx;
    logic                  hit;
    logic [2:0]            sel;

    ////////////////////////////////////////////////////////////////////
    // address decode
    // RQ1 RQ2 index decode
    assign idx = avs_address_in[FGT_ADDR_W+1:2];
    assign hit = (idx >= FGT_IDX_CONV0) && (idx <= FGT_IDX_CONV5);
    assign sel = 3'(idx - FGT_IDX_CONV0);

    ////////////////////////////////////////////////////////////////////
    // register file and bus answer
    always_comb begin
        s_d = s_q;
        s_d.waitreq = 1'b1;
        unique case (s_q.st)
            FGT_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    s_d.st      = FGT_ANSWER;
                    s_d.waitreq = 1'b0;
                    s_d.rdata   = FGT_UNMAPPED;
                    if (hit && avs_read_in) begin
                        s_d.rdata = {24'h00_0000, s_q.regs[sel]};
                    end
                end
            end
            FGT_ANSWER: begin
                s_d.st = FGT_IDLE;
                // RQ5 upper bits stored
                // RQ7 write lands on completion edge
                if (hit && avs_write_in && avs_byteenable_in[0]) begin
                    s_d.regs[sel] = avs_writedata_in[FGT_REG_W-1:0];
                end
            end
        endcase
        // RQ6 fuse defaults load
        if (fuse_load_in) begin
            s_d.regs = fuse_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q.st     <= FGT_IDLE;
            s_q.regs   <= {FGT_NUM_REGS{FGT_REG_RESET}};
            s_q.rdata  <= '0;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest_out = s_q.waitreq;
    assign avs_readdata_out    = s_q.rdata;

    ////////////////////////////////////////////////////////////////////
    // trim outputs
    // RQ1 RQ2 RQ7 continuous drive
    assign conv0_trim_out = s_q.regs[0][FGT_TRIM_MSB:FGT_TRIM_LSB];
    assign conv1_trim_out = s_q.regs[1][FGT_TRIM_MSB:FGT_TRIM_LSB];
    assign conv4_trim_out = s_q.regs[6][FGT_TRIM_MSB:FGT_TRIM_LSB];
    assign conv5_trim_out = s_q.regs[7][FGT_TRIM_MSB:FGT_TRIM_LSB];

    // RQ3 core two select
    fgt_trim_sel u_sel2 (
        .clk_sys_in     (clk_sys_in),
        .rstn_in        (rstn_in),
        .second_sel_in  (conv2_second_sel_in),
        .first_trim_in  (s_q.regs[2][FGT_TRIM_MSB:FGT_TRIM_LSB]),
        .second_trim_in (s_q.regs[3][FGT_TRIM_MSB:FGT_TRIM_LSB]),
        .trim_out       (conv2_trim_out)
    );

    // RQ4 core three select
    fgt_trim_sel u_sel3 (
        .clk_sys_in     (clk_sys_in),
        .rstn_in        (rstn_in),
        .second_sel_in  (conv3_second_sel_in),
        .first_trim_in  (s_q.regs[4][FGT_TRIM_MSB:FGT_TRIM_LSB]),
        .second_trim_in (s_q.regs[5][FGT_TRIM_MSB:FGT_TRIM_LSB]),
        .trim_out       (conv3_trim_out)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_write_conv0;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && idx == FGT_IDX_CONV0 && !fuse_load_in)
        |=> conv0_trim_out == $past(avs_writedata_in[4:0]);
    endproperty
    a_write_conv0: assert property (p_write_conv0) else $error("conv0 trim not updated by write"); // RQ1

    property p_write_conv5;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && idx == FGT_IDX_CONV5 && !fuse_load_in)
        |=> conv5_trim_out == $past(avs_writedata_in[4:0]);
    endproperty
    a_write_conv5: assert property (p_write_conv5) else $error("conv5 trim not updated by write"); // RQ2

    property p_fuse_load;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        fuse_load_in |=> s_q.regs == $past(fuse_data_in);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("fuse defaults not loaded"); // RQ6

    property p_answer;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_IDLE && (avs_read_in || avs_write_in)) |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer not one cycle after request"); // RQ7

    property p_readback;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_IDLE && avs_read_in && hit) |=> avs_readdata_out[31:8] == 24'h00_0000;
    endproperty
    a_readback: assert property (p_readback) else $error("upper read bits not zero"); // RQ5

    // RQ1 core one write
    property p_write_conv1;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && idx == FGT_IDX_CONV1 && !fuse_load_in)
        |=> conv1_trim_out == $past(avs_writedata_in[4:0]);
    endproperty
    a_write_conv1: assert property (p_write_conv1) else $error("conv1 trim not updated by write"); // RQ1

    // RQ2 core four write
    property p_write_conv4;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && idx == FGT_IDX_CONV4 && !fuse_load_in)
        |=> conv4_trim_out == $past(avs_writedata_in[4:0]);
    endproperty
    a_write_conv4: assert property (p_write_conv4) else $error("conv4 trim not updated by write"); // RQ2

    // RQ3 RQ4 every register stores its write
    for (genvar g = 0; g < FGT_NUM_REGS; g++) begin : g_write_chk
        property p_write_reg;
            @(posedge clk_sys_in) disable iff (!rstn_in)
            (s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && hit && sel == 3'(g) && !fuse_load_in)
            |=> s_q.regs[g] == $past(avs_writedata_in[FGT_REG_W-1:0]);
        endproperty
        a_write_reg: assert property (p_write_reg) else $error("addressed register did not store write"); // RQ3
    end

    // RQ7 trims hold between writes
    property p_trim_hold;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !(s_q.st == FGT_ANSWER && avs_write_in && avs_byteenable_in[0] && hit) && !fuse_load_in
        |=> $stable(s_q.regs);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed without a write"); // RQ7

    // RQ1 unmapped read zero
    property p_read_unmapped;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_IDLE && avs_read_in && !hit) |=> avs_readdata_out == FGT_UNMAPPED;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero"); // RQ1

    // RQ2 read returns stored byte
    property p_read_hit;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_IDLE && avs_read_in && hit) |=> avs_readdata_out[7:0] == $past(s_q.regs[sel]);
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("read data not the stored byte"); // RQ2

    // RQ7 no answer while idle
    property p_wait_idle;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_q.st == FGT_IDLE) |-> avs_waitrequest_out;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle"); // RQ7

    // RQ6 fuse byte reaches core zero
    property p_fuse_conv0;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        fuse_load_in |=> conv0_trim_out == $past(fuse_data_in[4:0]);
    endproperty
    a_fuse_conv0: assert property (p_fuse_conv0) else $error("fuse default missing on conv0"); // RQ6

    // RQ6 fuse byte reaches core five
    property p_fuse_conv5;
        @(posedge clk_sys_in) disable iff (!rstn_in)
        fuse_load_in |=> conv5_trim_out == $past(fuse_data_in[60:56]);
    endproperty
    a_fuse_conv5: assert property (p_fuse_conv5) else $error("fuse default missing on conv5"); // RQ6
endmodule : fgt_bank

// file: test/fgt_bank_tb.sv
// Purpose: self-checking bench for the fine gain trim bank
// Assumes: one-cycle bus answer, fuse load by one-cycle pulse
// Notes:   random trims from a fixed seed after a first round of 0x1f, selects set by round parity
module tb
    import fgt_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [13:0] avs_address_in = 14'h0000;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0]  avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        fuse_load_in = 1'b0;
    logic [63:0] fuse_data_in = 64'h0000_0000_0000_0000;
    logic        conv2_second_sel_in = 1'b0;
    logic        conv3_second_sel_in = 1'b0;
    logic [4:0]  conv0_trim_out, conv1_trim_out, conv2_trim_out;
    logic [4:0]  conv3_trim_out, conv4_trim_out, conv5_trim_out;
    logic [7:0]  mdl [8];
    logic [31:0] rd;
    int          seed = 32'h38b8_ee3c;
    int          error_cnt = 0;
    int          checked = 0;

    fgt_bank dut_u (.*);
    always #2.5 clk_sys_in = ~clk_sys_in;

    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic be);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        avs_writedata_in <= {24'hff_ff00, d};
        avs_byteenable_in <= {3'h0, be};
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        rd = avs_readdata_out;
        if (n >= 50) error_cnt++;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    function automatic logic [4:0] exp_trim(input int c);
        case (c)
            2: return conv2_second_sel_in ? mdl[3][4:0] : mdl[2][4:0];
            3: return conv3_second_sel_in ? mdl[5][4:0] : mdl[4][4:0];
            default: return (c < 2) ? mdl[c][4:0] : mdl[c + 2][4:0];
        endcase
    endfunction : exp_trim

    task automatic check_all;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check(avs_waitrequest_out, 1'b1);
        check(conv0_trim_out, exp_trim(0));
        check(conv1_trim_out, exp_trim(1));
        check(conv2_trim_out, exp_trim(2));
        check(conv3_trim_out, exp_trim(3));
        check(conv4_trim_out, exp_trim(4));
        check(conv5_trim_out, exp_trim(5));
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, FGT_IDX_CONV0 + 12'(k), 8'h00, 1'b0);
            check(rd, {24'h00_0000, mdl[k]});
        end
        bus(1'b0, 12'h0368, 8'h00, 1'b0);
        check(rd, FGT_UNMAPPED);
    endtask : check_all

    initial begin
        #200_000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        foreach (mdl[k]) mdl[k] = 8'h00;
        repeat (12) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        check_all();
        @(posedge clk_sys_in);
        fuse_data_in <= {$random(seed), $random(seed)};
        fuse_load_in <= 1'b1;
        @(posedge clk_sys_in);
        fuse_load_in <= 1'b0;
        foreach (mdl[k]) mdl[k] = fuse_data_in[8*k +: 8];
        check_all();
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 8; k++) begin
                mdl[k] = (r == 0) ? 8'h1f : {3'h0, 5'($random(seed))};
                bus(1'b1, FGT_IDX_CONV0 + 12'(k), mdl[k], 1'b1);
                #1;
                if (k == 0) check(conv0_trim_out, mdl[0][4:0]);
            end
            @(posedge clk_sys_in);
            conv2_second_sel_in <= r[0];
            conv3_second_sel_in <= ~r[0];
            check_all();
        end
        // unmapped and disabled-byte writes are dropped
        bus(1'b1, 12'h035f, 8'h15, 1'b1);
        bus(1'b1, 12'h0368, 8'h15, 1'b1);
        bus(1'b1, FGT_IDX_CONV1, 8'h0a, 1'b0);
        check_all();
        @(posedge clk_sys_in);
        rstn_in <= 1'b0;
        #1;
        check(avs_waitrequest_out, 1'b1);
        check(avs_readdata_out, 32'h0000_0000);
        check(conv0_trim_out, FGT_REG_RESET[4:0]);
        check(conv3_trim_out, FGT_REG_RESET[4:0]);
        repeat (3) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        foreach (mdl[k]) mdl[k] = FGT_REG_RESET;
        check_all();
        print_verdict();
    end
endmodule : tb
